// file: anpsel_pkg.sv
// Constants, types and register map of the shared alarm / negative rail / LCV pin selector
package anpsel_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned PIN_W = 11;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_MASK = 12'h008;
	localparam logic [11:0] OFF_LCV_CNT = 12'h00C;
	localparam logic [11:0] OFF_EXZ_CNT = 12'h010;
	localparam logic [11:0] OFF_PIN_STATE = 12'h014;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_TB_EN_BIT = 0;
	localparam int unsigned CTRL_MODE_LSB = 1;
	localparam int unsigned CTRL_EDGE_BIT = 3;
	localparam int unsigned EVT_AIS_BIT = 0;
	localparam int unsigned EVT_LCV_BIT = 1;
	localparam int unsigned EVT_EXZ_BIT = 2;

	// ----------------------------------------------------------------
	// Modes, roles and carriers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_STS1 = 2'h0,
		MODE_SINGLE = 2'h1,
		MODE_DUAL = 2'h2
	} anpsel_mode_e;

	typedef enum logic [1:0] {
		ROLE_UNUSED,
		ROLE_ALARM,
		ROLE_LCV,
		ROLE_NEG
	} anpsel_role_e;

	// Packed so that the struct image is the CTRL register image
	typedef struct packed {
		logic edge_fall;
		anpsel_mode_e mode;
		logic tb_en;
	} anpsel_ctrl_s;

	typedef struct packed {
		logic exz;
		logic lcv;
		logic ais;
	} anpsel_evt_s;

	// ----------------------------------------------------------------
	// Reset values and counts
	// ----------------------------------------------------------------
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [2:0] EVT_RST = 3'h0;
	localparam logic [2:0] MASK_RST = 3'h0;
	// One STS-1 frame of bus bytes without the strobe ends the defect
	localparam logic [9:0] AIS_CLR_BYTES = 10'h32A;

endpackage

// file: anpsel_sync.sv
// Two-flop synchroniser for a group of pins
`timescale 1ns/1ps
module anpsel_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			q_o <= '0;
		end else if (ce_i) begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end

endmodule

// file: anpsel_top.sv
// Function select and receive handling of the shared channel-0 alarm / neg rail / LCV pin
`timescale 1ns/1ps
module anpsel_top import anpsel_pkg::*; (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [DATA_W-1:0] pwdata_i,
	output logic [DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic shared_pin_i,
	input wire logic rx_line_clock_in_i,
	input wire logic tx_bus_clock_i,
	input wire logic [7:0] tx_bus_data_in_i,
	output logic ais_p_defect_o,
	output logic neg_rail_data_o,
	output logic neg_rail_valid_o,
	output logic lcv_event_o,
	output logic irq_o
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [PIN_W-1:0] pins_raw;
	logic [PIN_W-1:0] pins_s;
	logic pin_s;
	logic line_clk_s;
	logic tx_clk_s;
	logic [7:0] tx_data_s;
	logic line_clk_q;
	logic tx_clk_q;
	logic line_stb;
	logic tx_stb;
	anpsel_ctrl_s ctrl_q;
	anpsel_role_e role_q;
	anpsel_evt_s status_q;
	anpsel_evt_s mask_q;
	anpsel_evt_s evt_set;
	logic [7:0] tx_byte_q;
	logic [9:0] quiet_cnt_q;
	logic ais_q;
	logic lcv_prev_q;
	logic [CNT_W-1:0] lcv_cnt_q;
	logic [CNT_W-1:0] exz_cnt_q;
	logic neg_data_q;
	logic neg_valid_q;
	logic lcv_evt_q;
	logic irq_q;
	logic apb_acc;
	logic apb_wr;
	logic [DATA_W-1:0] rdata_c;
	logic hit_c;
	logic [DATA_W-1:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic lcv_hit;
	logic exz_hit;
	logic ais_evt;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	function automatic logic [CNT_W-1:0] cnt_next(input logic [CNT_W-1:0] c, input logic clr,
		input logic hit);
		cnt_next = (clr ? '0 : c) + {{(CNT_W-1){1'b0}}, hit};
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisation and edge finding
	// ----------------------------------------------------------------
	assign pins_raw = {tx_bus_data_in_i, tx_bus_clock_i, rx_line_clock_in_i, shared_pin_i};

	anpsel_sync #(.WIDTH(PIN_W)) u_sync (
		.clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.d_i(pins_raw),
		.q_o(pins_s)
	);

	assign pin_s = pins_s[0];
	assign line_clk_s = pins_s[1];
	assign tx_clk_s = pins_s[2];
	assign tx_data_s = pins_s[10:3];

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			line_clk_q <= 1'b0;
			tx_clk_q <= 1'b0;
		end else if (ce_i) begin
			line_clk_q <= line_clk_s;
			tx_clk_q <= tx_clk_s;
		end
	end

	// Pin and clocks share one synchroniser, so data seen at an edge keep their alignment
	assign line_stb = ctrl_q.edge_fall ? (line_clk_q & ~line_clk_s)
		: (line_clk_s & ~line_clk_q);
	assign tx_stb = tx_clk_s & ~tx_clk_q;

	// ----------------------------------------------------------------
	// Role selection
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			role_q <= ROLE_UNUSED;
		end else if (ce_i) begin
			if (ctrl_q.tb_en) begin
				role_q <= ROLE_ALARM;
			end else begin
				case (ctrl_q.mode)
					MODE_SINGLE: role_q <= ROLE_LCV;
					MODE_DUAL: role_q <= ROLE_NEG;
					default: role_q <= ROLE_UNUSED;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Telecom bus alarm strobe
	// ----------------------------------------------------------------
	assign ais_evt = (role_q == ROLE_ALARM) && tx_stb && pin_s;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			tx_byte_q <= 8'h00;
			quiet_cnt_q <= 10'h000;
			ais_q <= 1'b0;
		end else if (ce_i) begin
			if (role_q != ROLE_ALARM) begin
				quiet_cnt_q <= 10'h000;
				ais_q <= 1'b0;
			end else if (tx_stb) begin
				tx_byte_q <= tx_data_s;
				if (pin_s) begin
					ais_q <= 1'b1;
					quiet_cnt_q <= 10'h000;
				end else if (ais_q) begin
					if (quiet_cnt_q == AIS_CLR_BYTES - 10'h001) begin
						ais_q <= 1'b0;
						quiet_cnt_q <= 10'h000;
					end else begin
						quiet_cnt_q <= quiet_cnt_q + 10'h001;
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Line side: LCV counting and negative rail
	// ----------------------------------------------------------------
	// A high sample after a low is a code violation; each further high in a run is excessive zeros
	assign lcv_hit = (role_q == ROLE_LCV) && line_stb && pin_s && !lcv_prev_q;
	assign exz_hit = (role_q == ROLE_LCV) && line_stb && pin_s && lcv_prev_q;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			lcv_prev_q <= 1'b0;
			lcv_cnt_q <= '0;
			exz_cnt_q <= '0;
			lcv_evt_q <= 1'b0;
		end else if (ce_i) begin
			if (role_q != ROLE_LCV) begin
				lcv_prev_q <= 1'b0;
			end else if (line_stb) begin
				lcv_prev_q <= pin_s;
			end
			lcv_cnt_q <= cnt_next(lcv_cnt_q, apb_wr && (paddr_i == OFF_LCV_CNT), lcv_hit);
			exz_cnt_q <= cnt_next(exz_cnt_q, apb_wr && (paddr_i == OFF_EXZ_CNT), exz_hit);
			lcv_evt_q <= lcv_hit;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			neg_data_q <= 1'b0;
			neg_valid_q <= 1'b0;
		end else if (ce_i) begin
			neg_valid_q <= (role_q == ROLE_NEG) && line_stb;
			if ((role_q == ROLE_NEG) && line_stb) begin
				neg_data_q <= pin_s;
			end
		end
	end

	// ----------------------------------------------------------------
	// Status, mask and interrupt
	// ----------------------------------------------------------------
	assign evt_set = '{exz: exz_hit, lcv: lcv_hit, ais: ais_evt};

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			status_q <= EVT_RST;
			irq_q <= 1'b0;
		end else if (ce_i) begin
			// A new event in the clearing cycle stays set
			if (apb_wr && (paddr_i == OFF_STATUS)) begin
				status_q <= (status_q & ~pwdata_i[2:0]) | evt_set;
			end else begin
				status_q <= status_q | evt_set;
			end
			irq_q <= |(status_q & mask_q);
		end
	end

	// ----------------------------------------------------------------
	// APB slave, one wait state on every access
	// ----------------------------------------------------------------
	assign apb_acc = psel_i && penable_i && !pready_q;
	assign apb_wr = psel_i && penable_i && pwrite_i && pready_q;

	always_comb begin
		rdata_c = '0;
		hit_c = 1'b1;
		if (paddr_i == OFF_CTRL) begin
			rdata_c[3:0] = ctrl_q;
		end else if (paddr_i == OFF_STATUS) begin
			rdata_c[2:0] = status_q;
		end else if (paddr_i == OFF_MASK) begin
			rdata_c[2:0] = mask_q;
		end else if (paddr_i == OFF_LCV_CNT) begin
			rdata_c[CNT_W-1:0] = lcv_cnt_q;
		end else if (paddr_i == OFF_EXZ_CNT) begin
			rdata_c[CNT_W-1:0] = exz_cnt_q;
		end else if (paddr_i == OFF_PIN_STATE) begin
			rdata_c[11:0] = {tx_byte_q, role_q, neg_data_q, ais_q};
		end else begin
			hit_c = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			ctrl_q <= CTRL_RST;
			mask_q <= MASK_RST;
		end else if (ce_i && apb_wr) begin
			if (paddr_i == OFF_CTRL) begin
				ctrl_q <= pwdata_i[3:0];
			end else if (paddr_i == OFF_MASK) begin
				mask_q <= pwdata_i[2:0];
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			pready_q <= 1'b0;
			prdata_q <= '0;
			pslverr_q <= 1'b0;
		end else if (ce_i) begin
			pready_q <= apb_acc;
			prdata_q <= (apb_acc && !pwrite_i) ? rdata_c : '0;
			pslverr_q <= apb_acc && !hit_c;
		end
	end

	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign ais_p_defect_o = ais_q;
	assign neg_rail_data_o = neg_data_q;
	assign neg_rail_valid_o = neg_valid_q;
	assign lcv_event_o = lcv_evt_q;
	assign irq_o = irq_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_alarm_seen;
		ce_i && (role_q == ROLE_ALARM) && tx_stb && pin_s;
	endsequence

	sequence s_lcv_sample;
		ce_i && (role_q == ROLE_LCV) && line_stb && pin_s && !lcv_prev_q;
	endsequence

	property p_role_bus;
		ce_i && ctrl_q.tb_en |=> role_q == ROLE_ALARM;
	endproperty
	a_role_bus: assert property (p_role_bus) else $error("bus enabled but role not alarm");

	property p_role_mode;
		ce_i && !ctrl_q.tb_en && (ctrl_q.mode == MODE_DUAL) |=> role_q == ROLE_NEG;
	endproperty
	a_role_mode: assert property (p_role_mode) else $error("dual mode role wrong");

	property p_ais_declare;
		s_alarm_seen |=> ais_p_defect_o ##1 (!ce_i || irq_q || !mask_q.ais || status_q.ais);
	endproperty
	a_ais_declare: assert property (p_ais_declare) else $error("alarm did not declare defect");

	property p_lcv_count;
		s_lcv_sample and !(apb_wr && (paddr_i == OFF_LCV_CNT)) |=>
			(lcv_cnt_q == $past(lcv_cnt_q) + 16'h0001) && lcv_event_o;
	endproperty
	a_lcv_count: assert property (p_lcv_count) else $error("lcv counter missed a sample");

	property p_exz_count;
		ce_i && exz_hit && !(apb_wr && (paddr_i == OFF_EXZ_CNT)) |=>
			exz_cnt_q == $past(exz_cnt_q) + 16'h0001;
	endproperty
	a_exz_count: assert property (p_exz_count) else $error("exz counter missed a run");

	property p_single_only;
		ce_i && (role_q != ROLE_LCV) && !apb_wr |=> $stable(lcv_cnt_q) && $stable(exz_cnt_q);
	endproperty
	a_single_only: assert property (p_single_only) else $error("counted outside single rail");

	property p_edge_sel;
		ce_i && ctrl_q.edge_fall && line_clk_s && !line_clk_q |-> !line_stb;
	endproperty
	a_edge_sel: assert property (p_edge_sel) else $error("sampled on wrong line edge");

	property p_neg_rail;
		ce_i && (role_q == ROLE_NEG) && line_stb |=>
			neg_rail_valid_o && (neg_rail_data_o == $past(pin_s));
	endproperty
	a_neg_rail: assert property (p_neg_rail) else $error("negative rail sample lost");

	property p_bus_byte;
		s_alarm_seen |=> tx_byte_q == $past(tx_data_s);
	endproperty
	a_bus_byte: assert property (p_bus_byte) else $error("alarm not tied to bus byte");

	property p_irq;
		ce_i |=> irq_o == |($past(status_q) & $past(mask_q));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt level wrong");

	property p_apb_ready;
		ce_i && apb_acc ##1 ce_i |-> pready_o ##1 !pready_o;
	endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("apb ready not one cycle");

endmodule

// file: anpsel_far_model.sv
// Behavioural line interface unit and telecom bus source driving the shared pin
`timescale 1ns/1ps
module anpsel_far_model (
	input wire logic clk_i,
	input wire logic start_i,
	input wire logic [1:0] role_i,
	input wire logic edge_fall_i,
	input wire logic [15:0] bits_i,
	input wire logic [10:0] nbits_i,
	output logic busy_o,
	output logic pin_o,
	output logic line_clk_o,
	output logic bus_clk_o,
	output logic [7:0] bus_data_o
);
	// ----------------------------------------------------------------
	// Frame sequencer: eight core cycles per bit or bus byte
	// ----------------------------------------------------------------
	logic busy_q = 1'b0;
	logic last_q = 1'b1;
	logic [2:0] ph_q = 3'h0;
	logic [10:0] idx_q = 11'h000;
	logic cur;
	// Bits past the pattern are zero, so long quiet frames need no table
	assign cur = (idx_q < 11'h010) ? bits_i[idx_q[3:0]] : 1'b0;
	assign busy_o = busy_q;
	// Valid around the chosen edge only, inverse once hold has run out
	assign pin_o = (role_i == 2'h0) ? 1'b0 :
		!busy_q ? !last_q : (ph_q < 3'h6) ? cur : !cur;
	// Clocks stand still between frames; chosen edge always falls at phase 4
	assign line_clk_o = busy_q && (role_i == 2'h2) && ((ph_q >= 3'h4) ^ edge_fall_i);
	assign bus_clk_o = busy_q && (role_i == 2'h1) && (ph_q >= 3'h4);
	assign bus_data_o = busy_q ? idx_q[7:0] : ~idx_q[7:0];
	always @(posedge clk_i) begin
		if (start_i) begin
			busy_q <= 1'b1;
			ph_q <= 3'h0;
			idx_q <= 11'h000;
		end else if (busy_q) begin
			ph_q <= ph_q + 3'h1;
			if (ph_q == 3'h7) begin
				last_q <= cur;
				idx_q <= idx_q + 11'h001;
				if (idx_q == nbits_i - 11'h001)
					busy_q <= 1'b0;
			end
		end
	end
endmodule

// file: test_alarm_negrail_lcv_pin_select.sv
// Self-checking bench of the shared pin selector
`timescale 1ns/1ps
module test_alarm_negrail_lcv_pin_select import anpsel_pkg::*;;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = 12'h000;
	logic [DATA_W-1:0] pwdata = 32'h0;
	logic [DATA_W-1:0] prdata;
	logic pready, pslverr, ais, negd, negv, lcvev, irq, pin, lclk, bclk, busy, err;
	logic m_start = 1'b0, m_ef = 1'b0;
	logic ce = 1'b1;
	logic [1:0] m_role = 2'h0;
	logic [15:0] m_bits = 16'h0;
	logic [10:0] m_n = 11'h001;
	logic [7:0] bdata;
	logic [31:0] rd;
	int n_errors = 0;
	int compares = 0;
	int n_lcv = 0;
	int n_neg = 0;

	anpsel_top anpsel_top_inst (.core_clk_i(core_clk), .rst_n_i(rst_n), .ce_i(ce),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.shared_pin_i(pin), .rx_line_clock_in_i(lclk), .tx_bus_clock_i(bclk),
		.tx_bus_data_in_i(bdata), .ais_p_defect_o(ais), .neg_rail_data_o(negd),
		.neg_rail_valid_o(negv), .lcv_event_o(lcvev), .irq_o(irq));
	anpsel_far_model anpsel_far_model_inst (.clk_i(core_clk), .start_i(m_start),
		.role_i(m_role), .edge_fall_i(m_ef), .bits_i(m_bits), .nbits_i(m_n),
		.busy_o(busy), .pin_o(pin), .line_clk_o(lclk), .bus_clk_o(bclk), .bus_data_o(bdata));

	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (lcvev === 1'b1)
			n_lcv++;
		if (negv === 1'b1)
			n_neg++;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		chk(pready, 1'b1, "apb answer");
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, what);
	endtask
	// Line and bus frames; the pipeline settles within five core edges
	task automatic send(input logic [1:0] r, input logic ef, input logic [15:0] b,
		input logic [10:0] n);
		int k;
		k = 0;
		@(posedge core_clk);
		m_role <= r;
		m_ef <= ef;
		m_bits <= b;
		m_n <= n;
		m_start <= 1'b1;
		@(posedge core_clk);
		m_start <= 1'b0;
		do begin
			@(posedge core_clk);
			k++;
		end while (busy !== 1'b0 && k < 8000);
		chk(busy, 1'b0, "frame end");
		repeat (5) @(posedge core_clk);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic [11:0] offs [6] = '{OFF_CTRL, OFF_STATUS, OFF_MASK, OFF_LCV_CNT, OFF_EXZ_CNT,
			OFF_PIN_STATE};
		foreach (offs[i])
			rchk(offs[i], 32'h0, "reset value");
		apb(1'b1, OFF_PIN_STATE, 32'hF);
		rchk(OFF_PIN_STATE, 32'h0, "read-only pin state");
		apb(1'b0, 12'h018, 32'h0);
		chk({rd[30:0], err}, 32'h1, "unmapped read");
		$display("reset test done");
	endtask
	task automatic t_single(input logic ef);
		int ev;
		apb(1'b1, OFF_CTRL, {28'h0, ef, 3'h2});
		apb(1'b1, OFF_LCV_CNT, 32'h0);
		apb(1'b1, OFF_EXZ_CNT, 32'h0);
		apb(1'b1, OFF_STATUS, 32'h7);
		apb(1'b1, OFF_MASK, 32'h7);
		ev = n_lcv;
		send(2'h2, ef, 16'h0076, 11'h007);
		rchk(OFF_LCV_CNT, 32'h2, "lcv count");
		rchk(OFF_EXZ_CNT, 32'h3, "exz count");
		chk(n_lcv - ev, 32'h2, "lcv pulses");
		rchk(OFF_STATUS, 32'h6, "status");
		apb(1'b0, OFF_PIN_STATE, 32'h0);
		chk(rd[3:2], 32'h2, "lcv role");
		chk(irq, 32'h1, "irq raised");
		apb(1'b1, OFF_MASK, 32'h0);
		repeat (2) @(posedge core_clk);
		chk(irq, 32'h0, "irq masked");
		apb(1'b1, OFF_MASK, 32'h7);
		apb(1'b1, OFF_STATUS, 32'h6);
		repeat (2) @(posedge core_clk);
		chk(irq, 32'h0, "irq cleared");
		rchk(OFF_STATUS, 32'h0, "status cleared");
		$display("single rail test done");
	endtask
	// Clock enable low must freeze sampling, counting and status
	task automatic t_freeze();
		int ev;
		apb(1'b1, OFF_LCV_CNT, 32'h0);
		ev = n_lcv;
		@(posedge core_clk);
		ce <= 1'b0;
		send(2'h2, 1'b1, 16'h0076, 11'h007);
		ce <= 1'b1;
		rchk(OFF_LCV_CNT, 32'h0, "frozen lcv count");
		rchk(OFF_STATUS, 32'h0, "frozen status");
		chk(n_lcv - ev, 32'h0, "frozen lcv pulses");
		$display("freeze test done");
	endtask
	task automatic t_dual();
		int ev;
		int nv;
		apb(1'b1, OFF_CTRL, 32'h4);
		ev = n_lcv;
		nv = n_neg;
		send(2'h2, 1'b0, 16'h0005, 11'h003);
		chk(n_neg - nv, 32'h3, "neg samples");
		chk(negd, 32'h1, "last neg sample");
		chk(n_lcv - ev, 32'h0, "no lcv in dual");
		apb(1'b0, OFF_PIN_STATE, 32'h0);
		chk(rd[3:1], 32'h7, "neg role");
		$display("dual rail test done");
	endtask
	// Line pin must be ignored in the unused and bus roles, even when driven
	task automatic t_ignore();
		logic [3:0] ctl [3] = '{4'h0, 4'h6, 4'h3};
		logic [1:0] role [3] = '{2'h0, 2'h0, 2'h1};
		int ev;
		int nv;
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, OFF_CTRL, {28'h0, ctl[i]});
			ev = n_lcv;
			nv = n_neg;
			send(2'h2, 1'b0, 16'hFFFF, 11'h008);
			chk(n_lcv - ev + n_neg - nv, 32'h0, "line pin ignored");
			apb(1'b0, OFF_PIN_STATE, 32'h0);
			chk(rd[3:2], role[i], "role");
			chk(ais, 32'h0, "no defect");
		end
		$display("ignore test done");
	endtask
	task automatic t_alarm();
		apb(1'b1, OFF_CTRL, 32'h1);
		apb(1'b1, OFF_STATUS, 32'h7);
		send(2'h1, 1'b0, 16'h0004, 11'h003);
		chk(ais, 32'h1, "defect declared");
		apb(1'b0, OFF_PIN_STATE, 32'h0);
		chk(rd[11:4], 32'h02, "alarm byte");
		rchk(OFF_STATUS, 32'h1, "alarm status");
		send(2'h1, 1'b0, 16'h0000, 11'h329);
		chk(ais, 32'h1, "defect held");
		send(2'h1, 1'b0, 16'h0000, 11'h001);
		chk(ais, 32'h0, "defect ended");
		$display("alarm test done");
	endtask

	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset();
		t_single(1'b0);
		t_single(1'b1);
		t_freeze();
		t_dual();
		t_ignore();
		t_alarm();
		stop_test();
	end
	initial begin
		#(30000 * 25);
		n_errors++;
		$display("FAIL at %0t: watchdog expired", $time);
		stop_test();
	end
endmodule
